// file: design/tpo_pwm_output.v
// thermometer pulse-width output stage with sleep, wake and serial request
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "tpo_consts.vh"
module tpo_pwm_output #(
  parameter [21:0] WAKE_CYC  = `TPO_WAKE_CYC,
  parameter [21:0] REQ_CYC   = `TPO_REQ_CYC,
  parameter [21:0] FIRST_CYC = `TPO_FIRST_CYC,
  parameter [0:0]  AUTO_GRADE = 1'b1
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        scl_in,
  input  wire        sda_in,
  input  wire        sleep_command,
  input  wire        memory_double_error,
  output reg         pwm_out,
  output reg         pwm_oe,
  output reg         serial_mode,
  output reg         sleep_active,
  output reg         iir_bypass
);

  localparam [1:0] CH_AMB  = 2'd0;
  localparam [1:0] CH_OBJ1 = 2'd1;
  localparam [1:0] CH_OBJ2 = 2'd2;

  // software-visible state
  reg        output_enable;
  reg        push_pull_select;
  reg        ext_format;
  reg [4:0]  repeat_n;
  reg [1:0]  source_select;
  reg [15:0] prescale;
  reg [15:0] ambient_temperature;
  reg [15:0] object_temperature_one;
  reg [15:0] object_temperature_two;
  reg [15:0] ambient_range_bytes;
  reg [15:0] object_range_low;
  reg [15:0] object_range_high;

  // power and mode state
  reg        asleep;
  reg        pwm_disabled;
  reg        data_ready;
  reg        wake_armed;
  reg [21:0] wake_cnt;
  reg [21:0] req_cnt;
  reg [21:0] first_cnt;
  reg        wake_pulse;

  // rescale engine
  reg        eng_slot;
  reg        eng_busy;
  reg [3:0]  eng_bit;
  reg [26:0] eng_rem;
  reg [15:0] eng_den;
  reg [9:0]  eng_q;
  reg [9:0]  word_one;
  reg [9:0]  word_two;

  // frame generator
  reg [15:0] div_cnt;
  reg [11:0] pos;
  reg [11:0] high_end;
  reg        frame_ext;
  reg        slot;
  reg [5:0]  rep_cnt;

  // slot contents for each source code
  function [1:0] src_of;
    input [1:0] code;
    input       second;
    begin
      case (code)
        2'b00: src_of = second ? CH_OBJ1 : CH_AMB;
        2'b01: src_of = second ? CH_OBJ2 : CH_AMB;
        2'b11: src_of = second ? CH_OBJ2 : CH_OBJ1;
        default: src_of = CH_OBJ2;
      endcase
    end
  endfunction

  // end of the high part of a frame, in ticks
  function [11:0] hend;
    input       second;
    input       err;
    input [9:0] word;
    reg   [11:0] hi;
    begin
      hi = {2'b00, word} + {11'h000, word[9]};
      if (second)
        hend = err ? `TPO_S2_ERR : `TPO_S2_START + hi;
      else
        hend = err ? `TPO_S1_ERR : `TPO_S1_START + hi;
    end
  endfunction

  wire pwm_active = output_enable & ~pwm_disabled & ~asleep & data_ready;
  wire fatal_err  = memory_double_error & AUTO_GRADE;

  // apb decode
  wire setup_ph = psel & ~penable;
  wire access_ok = psel & penable & pready;
  reg        rd_hit;
  reg [31:0] rd_data;

  always @* begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr == `TPO_OFF_CTRL) begin
      rd_data[`TPO_CTL_EN] = output_enable;
      rd_data[`TPO_CTL_PP] = push_pull_select;
      rd_data[`TPO_CTL_EXT] = ext_format;
      rd_data[`TPO_CTL_REP_MSB:`TPO_CTL_REP_LSB] = repeat_n;
    end else if (paddr == `TPO_OFF_CONFIG) begin
      rd_data[`TPO_CFG_SRC_MSB:`TPO_CFG_SRC_LSB] = source_select;
    end else if (paddr == `TPO_OFF_PRESCALE) begin
      rd_data[15:0] = prescale;
    end else if (paddr == `TPO_OFF_AMB) begin
      rd_data[15:0] = ambient_temperature;
    end else if (paddr == `TPO_OFF_OBJ1) begin
      rd_data[15:0] = object_temperature_one;
    end else if (paddr == `TPO_OFF_OBJ2) begin
      rd_data[15:0] = object_temperature_two;
    end else if (paddr == `TPO_OFF_ARANGE) begin
      rd_data[15:0] = ambient_range_bytes;
    end else if (paddr == `TPO_OFF_OLOW) begin
      rd_data[15:0] = object_range_low;
    end else if (paddr == `TPO_OFF_OHIGH) begin
      rd_data[15:0] = object_range_high;
    end else if (paddr == `TPO_OFF_STATUS) begin
      rd_data[4:0] = {fatal_err, data_ready, asleep, pwm_disabled, pwm_active};
    end else if (paddr == `TPO_OFF_WORDS) begin
      rd_data[9:0] = word_one;
      rd_data[25:16] = word_two;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // bus answer: ready in every access phase, one wait-free cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~rd_hit;
      if (setup_ph)
        prdata <= (rd_hit & ~pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // configuration writes; nonvolatile, so a wake does not touch them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_enable <= 1'b0;
      push_pull_select <= 1'b0;
      ext_format <= 1'b0;
      repeat_n <= 5'h00;
      source_select <= 2'b00;
      prescale <= `TPO_RST_PRESCALE;
      ambient_temperature <= 16'h0000;
      object_temperature_one <= 16'h0000;
      object_temperature_two <= 16'h0000;
      ambient_range_bytes <= `TPO_RST_ARANGE;
      object_range_low <= `TPO_RST_OLOW;
      object_range_high <= `TPO_RST_OHIGH;
    end else if (access_ok & pwrite) begin
      if (paddr == `TPO_OFF_CTRL) begin
        output_enable <= pwdata[`TPO_CTL_EN];
        push_pull_select <= pwdata[`TPO_CTL_PP];
        ext_format <= pwdata[`TPO_CTL_EXT];
        repeat_n <= pwdata[`TPO_CTL_REP_MSB:`TPO_CTL_REP_LSB];
      end else if (paddr == `TPO_OFF_CONFIG) begin
        source_select <= pwdata[`TPO_CFG_SRC_MSB:`TPO_CFG_SRC_LSB];
      end else if (paddr == `TPO_OFF_PRESCALE) begin
        prescale <= pwdata[15:0];
      end else if (paddr == `TPO_OFF_AMB) begin
        ambient_temperature <= pwdata[15:0];
      end else if (paddr == `TPO_OFF_OBJ1) begin
        object_temperature_one <= pwdata[15:0];
      end else if (paddr == `TPO_OFF_OBJ2) begin
        object_temperature_two <= pwdata[15:0];
      end else if (paddr == `TPO_OFF_ARANGE) begin
        ambient_range_bytes <= pwdata[15:0];
      end else if (paddr == `TPO_OFF_OLOW) begin
        object_range_low <= pwdata[15:0];
      end else if (paddr == `TPO_OFF_OHIGH) begin
        object_range_high <= pwdata[15:0];
      end
    end
  end

  // sleep entry, wake sequence, switch request and first-data timer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asleep <= 1'b0;
      pwm_disabled <= 1'b0;
      data_ready <= 1'b0;
      wake_armed <= 1'b0;
      wake_cnt <= 22'h000000;
      req_cnt <= 22'h000000;
      first_cnt <= 22'h000000;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (asleep) begin
        // clock must be seen high with data high before data falls
        if (!scl_in) begin
          wake_armed <= 1'b0;
          wake_cnt <= 22'h000000;
        end else if (sda_in) begin
          wake_armed <= 1'b1;
          wake_cnt <= 22'h000000;
        end else if (wake_armed) begin
          if (wake_cnt == WAKE_CYC - 22'h000001) begin
            asleep <= 1'b0;
            wake_pulse <= 1'b1;
            pwm_disabled <= 1'b0;
            data_ready <= 1'b0;
            first_cnt <= 22'h000000;
            wake_armed <= 1'b0;
            wake_cnt <= 22'h000000;
          end else begin
            wake_cnt <= wake_cnt + 22'h000001;
          end
        end
      end else begin
        if (sleep_command & ~pwm_active) begin
          asleep <= 1'b1;
          wake_armed <= 1'b0;
          req_cnt <= 22'h000000;
        end
        // long low clock while pulsing hands the pin to the serial bus
        if (pwm_active & ~scl_in) begin
          if (req_cnt == REQ_CYC - 22'h000001)
            pwm_disabled <= 1'b1;
          else
            req_cnt <= req_cnt + 22'h000001;
        end else begin
          req_cnt <= 22'h000000;
        end
        if (!data_ready) begin
          if (first_cnt == FIRST_CYC - 22'h000001)
            data_ready <= 1'b1;
          else
            first_cnt <= first_cnt + 22'h000001;
        end
      end
    end
  end

  // rescale engine inputs for the slot being worked on
  reg [1:0]  e_src;
  reg [15:0] e_val;
  reg [15:0] e_lo;
  reg [15:0] e_hi;
  reg [15:0] e_diff;
  reg [26:0] e_shift;
  reg        e_fit;
  reg [9:0]  e_qn;

  always @* begin
    e_src = src_of(source_select, eng_slot);
    e_val = (e_src == CH_AMB) ? ambient_temperature :
            (e_src == CH_OBJ1) ? object_temperature_one : object_temperature_two;
    // ambient bytes step 32 raw counts from the lowest readable ambient
    e_lo = object_range_low;
    e_hi = object_range_high;
    if (e_src == CH_AMB) begin
      e_lo = `TPO_AMB_BASE + {3'b000, ambient_range_bytes[7:0], 5'h00};
      e_hi = `TPO_AMB_BASE + {3'b000, ambient_range_bytes[15:8], 5'h00};
    end
    e_diff = e_val - e_lo;
    e_shift = {11'h000, eng_den} << eng_bit;
    e_fit = (eng_rem >= e_shift);
    e_qn = eng_q | (e_fit ? (10'h001 << eng_bit) : 10'h000);
  end

  // restoring division, eleven cycles per divided word (one load, ten steps), slots take turns
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_slot <= 1'b0;
      eng_busy <= 1'b0;
      eng_bit <= 4'h0;
      eng_rem <= 27'h0000000;
      eng_den <= 16'h0000;
      eng_q <= 10'h000;
      word_one <= 10'h000;
      word_two <= 10'h000;
    end else if (!eng_busy) begin
      if ((e_val <= e_lo) || (e_val >= e_hi)) begin
        // clamp to the range ends; also covers an empty range
        if (eng_slot)
          word_two <= (e_val <= e_lo) ? 10'h000 : `TPO_WORD_MAX;
        else
          word_one <= (e_val <= e_lo) ? 10'h000 : `TPO_WORD_MAX;
        eng_slot <= ~eng_slot;
      end else begin
        eng_rem <= {1'b0, e_diff, 10'h000} - {11'h000, e_diff};
        eng_den <= e_hi - e_lo;
        eng_bit <= 4'h9;
        eng_q <= 10'h000;
        eng_busy <= 1'b1;
      end
    end else begin
      if (e_fit)
        eng_rem <= eng_rem - e_shift;
      eng_q <= e_qn;
      if (eng_bit == 4'h0) begin
        eng_busy <= 1'b0;
        eng_slot <= ~eng_slot;
        if (eng_slot)
          word_two <= e_qn;
        else
          word_one <= e_qn;
      end else begin
        eng_bit <= eng_bit - 4'h1;
      end
    end
  end

  // frame sequencing; tick rate sets the period
  wire        tick = (div_cnt == prescale);
  wire [11:0] last = frame_ext ? `TPO_EXT_LAST : `TPO_SINGLE_LAST;
  reg         next_slot;
  reg [5:0]   next_rep;

  always @* begin
    next_slot = 1'b0;
    next_rep = 6'h00;
    if (ext_format) begin
      next_slot = slot;
      next_rep = rep_cnt + 6'h01;
      if (!frame_ext || rep_cnt == {repeat_n, 1'b0}) begin
        next_slot = frame_ext ? ~slot : 1'b0;
        next_rep = 6'h00;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      pos <= 12'h000;
      high_end <= 12'h000;
      frame_ext <= 1'b0;
      slot <= 1'b0;
      rep_cnt <= 6'h00;
    end else if (!pwm_active || wake_pulse) begin
      // idle: hold at a frame start with the first slot queued
      div_cnt <= 16'h0000;
      pos <= 12'h000;
      frame_ext <= ext_format;
      slot <= 1'b0;
      rep_cnt <= 6'h00;
      high_end <= hend(1'b0, fatal_err, word_one);
    end else if (tick) begin
      div_cnt <= 16'h0000;
      if (pos == last) begin
        pos <= 12'h000;
        frame_ext <= ext_format;
        slot <= next_slot;
        rep_cnt <= next_rep;
        high_end <= hend(next_slot, fatal_err,
                         next_slot ? word_two : word_one);
      end else begin
        pos <= pos + 12'h001;
      end
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // pin drive: push-pull drives both levels, otherwise only the low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
      pwm_oe <= 1'b0;
      serial_mode <= 1'b1;
      sleep_active <= 1'b0;
      iir_bypass <= 1'b1;
    end else begin
      pwm_out <= pwm_active & (pos < high_end);
      pwm_oe <= pwm_active & (push_pull_select | ~(pos < high_end));
      serial_mode <= ~(output_enable & ~pwm_disabled & ~asleep);
      sleep_active <= asleep;
      iir_bypass <= ~data_ready;
    end
  end

endmodule // tpo_pwm_output

// file: design/tpo_consts.vh
// constants of the thermometer pulse-width output block
`ifndef TPO_CONSTS_VH
`define TPO_CONSTS_VH
// clock and timing, times in microseconds
`define TPO_CLK_MHZ 10
`define TPO_WAKE_HOLD_US 80000
`define TPO_REQ_US 1440
`define TPO_FIRST_DATA_US 250000
`define TPO_WAKE_CYC (`TPO_WAKE_HOLD_US * `TPO_CLK_MHZ)
`define TPO_REQ_CYC (`TPO_REQ_US * `TPO_CLK_MHZ + 1)
`define TPO_FIRST_CYC (`TPO_FIRST_DATA_US * `TPO_CLK_MHZ)
// register byte offsets
`define TPO_OFF_CTRL 8'h00
`define TPO_OFF_CONFIG 8'h04
`define TPO_OFF_PRESCALE 8'h08
`define TPO_OFF_AMB 8'h0c
`define TPO_OFF_OBJ1 8'h10
`define TPO_OFF_OBJ2 8'h14
`define TPO_OFF_ARANGE 8'h18
`define TPO_OFF_OLOW 8'h1c
`define TPO_OFF_OHIGH 8'h20
`define TPO_OFF_STATUS 8'h24
`define TPO_OFF_WORDS 8'h28
// control and config word fields
`define TPO_CTL_EN 0
`define TPO_CTL_PP 1
`define TPO_CTL_EXT 2
`define TPO_CTL_REP_LSB 4
`define TPO_CTL_REP_MSB 8
`define TPO_CFG_SRC_LSB 4
`define TPO_CFG_SRC_MSB 5
// reset values
`define TPO_RST_PRESCALE 16'h0004
`define TPO_RST_ARANGE 16'h993c
`define TPO_RST_OLOW 16'h6ab3
`define TPO_RST_OHIGH 16'h7e3b
// frame layout in ticks, single frame 2048, extended 4096
`define TPO_SINGLE_LAST 12'h7ff
`define TPO_EXT_LAST 12'hfff
`define TPO_S1_START 12'h100
`define TPO_S1_ERR 12'h700
`define TPO_S2_START 12'h900
`define TPO_S2_ERR 12'hf00
// rescale
`define TPO_AMB_BASE 16'h2de4
`define TPO_AMB_SHIFT 5
`define TPO_WORD_MAX 10'h3ff
`endif

// file: tb/tpo_sva.sv
// port assertions for the pulse-width output stage
`timescale 1ns/10ps
module tpo_sva #(
  parameter [21:0] WAKE_CYC  = 22'h14,
  parameter [21:0] REQ_CYC   = 22'ha,
  parameter [21:0] FIRST_CYC = 22'h1e
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        scl_in,
  input wire        sda_in,
  input wire        pwm_oe,
  input wire        sleep_active,
  input wire        iir_bypass
);
  reg [22:0] lo_n;
  reg [22:0] wk_n;
  reg [22:0] by_n;
  reg        arm;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // run lengths: clock line low, wake hold, first-result window
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_n <= 23'h0;
      wk_n <= 23'h0;
      by_n <= 23'h0;
      arm  <= 1'b0;
    end else begin
      lo_n <= scl_in ? 23'h0 : lo_n + 23'h1;
      arm  <= sleep_active & scl_in & (arm | sda_in); // data must be seen high first
      wk_n <= (arm & scl_in & ~sda_in) ? wk_n + 23'h1 : 23'h0;
      by_n <= (iir_bypass & ~sleep_active) ? by_n + 23'h1 : 23'h0;
    end
  end
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  req_switch_a: assert property (lo_n == REQ_CYC + 2 |-> ##[0:2] !pwm_oe)
    else $error("pin not released after long clock low");
  wake_exit_a: assert property (wk_n == WAKE_CYC |-> ##[0:3] !sleep_active)
    else $error("no wake after data low hold");
  wake_bypass_a: assert property ($fell(sleep_active) |=> iir_bypass [*8])
    else $error("filter bypass missing after wake");
  bypass_max_a: assert property (by_n <= FIRST_CYC + 4)
    else $error("first result late");
  bypass_min_a: assert property ($fell(iir_bypass) |-> by_n + 4 >= FIRST_CYC)
    else $error("first result early");
  quiet_early_a: assert property (iir_bypass || sleep_active |-> !pwm_oe)
    else $error("pin driven before first result");
endmodule // tpo_sva

bind tpo_pwm_output tpo_sva #(.WAKE_CYC(WAKE_CYC), .REQ_CYC(REQ_CYC),
  .FIRST_CYC(FIRST_CYC)) chk_u (.*);

// file: tb/tpo_host.sv
// two-wire master and pulse-width reader on the shared data pin
`timescale 1ns/10ps
module tpo_host (
  input  wire        pclk,
  input  wire        pwm_out,
  input  wire        pwm_oe,
  output reg         scl,
  output wire        sda,
  output reg  [15:0] hi_len,
  output reg  [15:0] n_pulse
);
  reg        m_sda;
  reg [15:0] run;
  // pulled-up line, low while either side pulls it
  assign sda = m_sda & ~(pwm_oe & ~pwm_out);
  initial begin
    scl     = 1'b1;
    m_sda   = 1'b1;
    run     = 16'h0;
    hi_len  = 16'h0;
    n_pulse = 16'h0;
  end
  // high time of each pulse, taken at its falling edge
  always @(posedge pclk) begin
    if (sda) begin
      run <= run + 16'h1;
    end else begin
      if (run != 16'h0) begin
        hi_len  <= run;
        n_pulse <= n_pulse + 16'h1;
      end
      run <= 16'h0;
    end
  end
  // clock line low for n cycles, a serial request when long enough
  task req(input integer n);
    begin
      scl <= 1'b0;
      repeat (n) @(posedge pclk);
      scl <= 1'b1;
      @(posedge pclk);
    end
  endtask
  // clock low through sleep keeps pin leakage down
  task park;
    begin
      scl <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // clock high with data high, then data low for n cycles
  task wake(input integer n);
    begin
      scl <= 1'b1;
      repeat (2) @(posedge pclk);
      m_sda <= 1'b0;
      repeat (n) @(posedge pclk);
      m_sda <= 1'b1;
      @(posedge pclk);
    end
  endtask
endmodule // tpo_host

// file: tb/tpo_pwm_output_tb.sv
// self-checking bench for the pulse-width output stage
`timescale 1ns/10ps
`include "tpo_consts.vh"
`define CHK(a, b) \
  begin \
    cmp_count = cmp_count + 1; \
    if ((a) !== (b)) begin \
      n_fail = n_fail + 1; \
      $display("wrong value at %0t: got %0h want %0h", $time, a, b); \
    end \
  end
module tpo_pwm_output_tb;
  localparam integer AL = `TPO_AMB_BASE + (16'h3c << `TPO_AMB_SHIFT);
  localparam integer AH = `TPO_AMB_BASE + (16'h99 << `TPO_AMB_SHIFT);
  localparam integer TA = 16'h3a00;
  reg         pclk, presetn, psel, penable, pwrite, slp, mde, er;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [15:0] w, v, e;
  wire [31:0] prdata;
  wire        pready, pslverr, scl, sda, pwm_out, pwm_oe, ser, asleep, byp;
  wire [15:0] hi_len, n_pulse;
  integer     n_fail, cmp_count, cyc, c, k;
  tpo_pwm_output #(.WAKE_CYC(22'h14), .REQ_CYC(22'ha), .FIRST_CYC(22'h1e)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
    .sleep_command(slp), .memory_double_error(mde), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .serial_mode(ser), .sleep_active(asleep), .iir_bypass(byp));
  tpo_host hp_u (.pclk(pclk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .scl(scl),
    .sda(sda), .hi_len(hi_len), .n_pulse(n_pulse));
  // one transfer, held until ready is seen at an edge
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // next captured high time, taken on the edge after the reader updates
  task pw;
    begin
      @(n_pulse);
      @(posedge pclk);
      w = hi_len;
    end
  endtask
  // words load at frame start, so the second pulse already carries the change
  task pw3;
    begin
      pw;
      pw;
    end
  endtask
  // drive enable seen while the output is high
  task oe_chk(input x);
    begin
      wait (pwm_out === 1'b1);
      @(posedge pclk);
      `CHK(pwm_oe, x)
    end
  endtask
  // expected slot-one high time for a raw temperature
  function [15:0] hi_t(input integer t, input integer lo, input integer hi);
    integer q;
    begin
      q = (t <= lo) ? 0 : (t >= hi) ? 1023 : (t - lo) * 1023 / (hi - lo);
      hi_t = 16'h100 + q + q / 512;
    end
  endfunction
  task wrap_up;
    begin
      if (n_fail == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // hang limit well past the expected run length
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 95000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  initial begin
    {psel, penable, pwrite, slp, mde, presetn} = 6'h0;
    {paddr, pwdata, w, v} = 72'h0;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(ser, 1'b1)
    apb(1'b0, `TPO_OFF_ARANGE, 32'h0);
    `CHK(rd, 32'h993c)
    apb(1'b0, 8'h2c, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, `TPO_OFF_PRESCALE, 32'h0);
    apb(1'b1, `TPO_OFF_AMB, TA);
    apb(1'b1, `TPO_OFF_OBJ1, 32'h6ab3);
    apb(1'b1, `TPO_OFF_OBJ2, 32'h8000);
    apb(1'b1, `TPO_OFF_CTRL, 32'h1);
    // every source code in the single format: slot one only
    for (c = 0; c < 4; c = c + 1) begin
      apb(1'b1, `TPO_OFF_CONFIG, c << 4);
      e = (c < 2) ? hi_t(TA, AL, AH) : (c == 3) ? 16'h100 : 16'h500;
      pw3;
      `CHK(w, e)
    end
    oe_chk(1'b0);
    mde <= 1'b1;
    pw3;
    `CHK(w, 16'h700)
    mde <= 1'b0;
    // extended, push-pull, three frames per slot
    apb(1'b1, `TPO_OFF_CTRL, 32'h17);
    for (k = 0; k < 14 && !(v === 16'hd00 && w === 16'h100); k = k + 1) begin
      v = w;
      pw;
    end
    `CHK(w, 16'h100)
    pw;
    `CHK(w, 16'h100)
    pw;
    `CHK(w, 16'h100)
    pw;
    `CHK(w, 16'hd00)
    oe_chk(1'b1);
    slp <= 1'b1;
    @(posedge pclk);
    slp <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(asleep, 1'b0)
    hp_u.req(8);
    repeat (3) @(posedge pclk);
    `CHK(ser, 1'b0)
    hp_u.req(14);
    repeat (3) @(posedge pclk);
    `CHK(ser, 1'b1)
    repeat (4200) @(posedge pclk);
    `CHK(ser, 1'b1)
    slp <= 1'b1;
    @(posedge pclk);
    slp <= 1'b0;
    hp_u.park;
    repeat (3) @(posedge pclk);
    `CHK(asleep, 1'b1)
    hp_u.wake(17);
    `CHK(asleep, 1'b1)
    hp_u.wake(22);
    `CHK(asleep, 1'b0)
    `CHK(byp, 1'b1)
    repeat (40) @(posedge pclk);
    `CHK(byp, 1'b0)
    pw3;
    `CHK(w === 16'h100 || w === 16'hd00, 1'b1)
    wrap_up;
  end
endmodule // tpo_pwm_output_tb
